// ### logic/ppp_port.sv
`timescale 1ns/10ps
`include "ppp_cfg.svh"
// Summary of operation
// - ready_busy_n low during erase or programming, high when ready.
// - data bus driven only while read_drive_n is low.
// - byte_sel_first picks low or high byte for address loads, data loads and flash reads.
// - byte_sel_second picks low or second high byte.
// - load strobe action: 00 address, 01 data, 10 command, 11 none.
// - address load goes to low or high byte per byte_sel_first.
// - write commands: erase, fuses, locks, flash, eeprom.
// - read commands: signature, fuse/lock, flash, eeprom.
// - program or read strobe runs the last loaded command.
// - command and address kept across operations.
// - erase clears flash, eeprom, locks; fuses kept; locks cleared in the same cycle as flash.
// - keep_eeprom_fuse keeps eeprom through erase.
// - erase starts on program strobe low, busy until done.
// - page latch pulse stores loaded word at current address.
// - low address bits pick word, upper bits pick page.
// - program strobe with byte_sel_first low writes whole page.
// - fuses captured at entry; keep_eeprom_fuse acts at once.
// - no-operation command resets internal write signals.
module ppp_port #(
  parameter int FLASH_AW = 16,
  parameter int PAGE_BITS = 7,
  parameter int EEP_AW = 12,
  parameter int EEP_PAGE_BITS = 3,
  parameter int ERASE_CYC = `PPP_ERASE_NS / `PPP_CLK_NS,
  parameter int PROG_CYC = `PPP_PROG_NS / `PPP_CLK_NS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // programming pins
  input wire logic prog_mode,
  input wire logic load_strobe_pin,
  input wire ppp_pkg::ppp_sel_t sel,
  input wire logic read_drive_n,
  input wire logic program_strobe_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic ready_busy_n,
  // fuse and lock state
  output logic [7:0] fuse_low_active,
  output logic [7:0] fuse_high_active,
  output logic [7:0] fuse_ext_active,
  output logic [7:0] lock_bits
);
  import ppp_pkg::*;
  localparam int PW = 1 << PAGE_BITS;
  localparam int EPW = 1 << EEP_PAGE_BITS;
  localparam int KEEP_BIT = 3;

  logic [(1<<FLASH_AW)-1:0][15:0] flash_mem;
  logic [(1<<EEP_AW)-1:0][7:0] eep_mem;
  logic [PW-1:0][15:0] page_buf;
  logic [EPW-1:0][7:0] epage_buf;
  logic [7:0] cmd_reg, addr_lo_reg, addr_hi_reg, dlo_reg, dhi_reg;
  logic [7:0] fuse_lo_reg, fuse_hi_reg, fuse_ext_reg;
  logic ls_d, pl_d, wr_d, mode_d;
  logic ls_rise, pl_rise, wr_fall;
  logic [31:0] cnt_reg;
  ppp_state_t st_reg;
  logic [15:0] addr;
  logic [1:0] act;
  logic busy;

  assign addr = {addr_hi_reg, addr_lo_reg};
  assign act = {sel.strobe_action_msb, sel.strobe_action_lsb};
  assign ls_rise = load_strobe_pin & ~ls_d;
  assign pl_rise = sel.page_buffer_latch & ~pl_d;
  assign wr_fall = ~program_strobe_n & wr_d;
  assign busy = (st_reg != PPP_IDLE);

  assign ready_busy_n = ~busy;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ls_d <= 1'b0;
      pl_d <= 1'b0;
      wr_d <= 1'b1;
      mode_d <= 1'b0;
    end else if (clk_en) begin
      ls_d <= load_strobe_pin;
      pl_d <= sel.page_buffer_latch;
      wr_d <= program_strobe_n;
      mode_d <= prog_mode;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_reg <= `PPP_CMD_NOP;
      addr_lo_reg <= `PPP_ZERO8;
      addr_hi_reg <= `PPP_ZERO8;
      dlo_reg <= `PPP_ZERO8;
      dhi_reg <= `PPP_ZERO8;
    end else if (clk_en && prog_mode && ls_rise && !busy) begin
      case (act)
        `PPP_ACT_ADDR: begin
          if (sel.byte_sel_first) addr_hi_reg <= data_in;
          else addr_lo_reg <= data_in;
        end
        `PPP_ACT_DATA: begin
          if (sel.byte_sel_first) dhi_reg <= data_in;
          else dlo_reg <= data_in;
        end
        `PPP_ACT_CMD: cmd_reg <= data_in;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      page_buf <= '1;
      epage_buf <= '1;
    end else if (clk_en) begin
      if (ls_rise && act == `PPP_ACT_CMD && data_in == `PPP_CMD_NOP
          && !busy) begin
        page_buf <= '1;
        epage_buf <= '1;
      end else if (prog_mode && pl_rise && !busy) begin
        if (cmd_reg == `PPP_CMD_WFLASH)
          page_buf[addr[PAGE_BITS-1:0]] <= {dhi_reg, dlo_reg};
        else if (cmd_reg == `PPP_CMD_WEEP)
          epage_buf[addr[EEP_PAGE_BITS-1:0]] <= dlo_reg;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= PPP_IDLE;
      cnt_reg <= '0;
    end else if (clk_en) begin
      case (st_reg)
        PPP_IDLE: begin
          if (prog_mode && wr_fall) begin
            if (cmd_reg == `PPP_CMD_ERASE) begin
              st_reg <= PPP_ERASE;
              cnt_reg <= 32'(ERASE_CYC);
            end else if (!sel.byte_sel_first &&
                (cmd_reg == `PPP_CMD_WFLASH || cmd_reg == `PPP_CMD_WEEP ||
                 cmd_reg == `PPP_CMD_WFUSE || cmd_reg == `PPP_CMD_WLOCK))
            begin
              st_reg <= PPP_PROG;
              cnt_reg <= 32'(PROG_CYC);
            end else if (cmd_reg == `PPP_CMD_WFUSE ||
                cmd_reg == `PPP_CMD_WLOCK) begin
              st_reg <= PPP_PROG;
              cnt_reg <= 32'(PROG_CYC);
            end
          end
        end
        PPP_ERASE, PPP_PROG: begin
          if (cnt_reg <= 32'd1) st_reg <= PPP_IDLE;
          cnt_reg <= cnt_reg - 32'd1;
        end
        default: st_reg <= PPP_IDLE;
      endcase
    end
  end

  // memory commit at end of operation
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flash_mem <= '1;
      eep_mem <= '1;
    end else if (clk_en && busy && cnt_reg == 32'd1) begin
      if (st_reg == PPP_ERASE) begin
        flash_mem <= '1;
        if (fuse_hi_reg[KEEP_BIT]) eep_mem <= '1;
      end else if (cmd_reg == `PPP_CMD_WFLASH) begin
        for (int i = 0; i < PW; i++)
          flash_mem[{addr[FLASH_AW-1:PAGE_BITS], PAGE_BITS'(i)}] <=
            page_buf[i];
      end else if (cmd_reg == `PPP_CMD_WEEP) begin
        for (int i = 0; i < EPW; i++)
          eep_mem[{addr[EEP_AW-1:EEP_PAGE_BITS], EEP_PAGE_BITS'(i)}] <=
            epage_buf[i];
      end
    end
  end

  // fuse and lock cells
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fuse_lo_reg <= `PPP_ERASED8;
      fuse_hi_reg <= `PPP_ERASED8;
      fuse_ext_reg <= `PPP_ERASED8;
      lock_bits <= `PPP_ERASED8;
    end else if (clk_en && busy && cnt_reg == 32'd1) begin
      if (st_reg == PPP_ERASE) lock_bits <= `PPP_ERASED8;
      else if (cmd_reg == `PPP_CMD_WLOCK) lock_bits <= lock_bits & dlo_reg;
      else if (cmd_reg == `PPP_CMD_WFUSE) begin
        if (sel.byte_sel_second) fuse_ext_reg <= dlo_reg;
        else if (sel.byte_sel_first) fuse_hi_reg <= dlo_reg;
        else fuse_lo_reg <= dlo_reg;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fuse_low_active <= `PPP_ERASED8;
      fuse_high_active <= `PPP_ERASED8;
      fuse_ext_active <= `PPP_ERASED8;
    end else if (clk_en && prog_mode && !mode_d) begin
      fuse_low_active <= fuse_lo_reg;
      fuse_high_active <= fuse_hi_reg;
      fuse_ext_active <= fuse_ext_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) data_out <= `PPP_ZERO8;
    else if (clk_en) begin
      case (cmd_reg)
        `PPP_CMD_RFLASH:
          data_out <= sel.byte_sel_first ? flash_mem[addr][15:8]
                                         : flash_mem[addr][7:0];
        `PPP_CMD_REEP: data_out <= eep_mem[addr[EEP_AW-1:0]];
        `PPP_CMD_RFUSE: begin
          case ({sel.byte_sel_second, sel.byte_sel_first})
            2'b00: data_out <= fuse_lo_reg;
            2'b11: data_out <= fuse_hi_reg;
            2'b10: data_out <= fuse_ext_reg;
            default: data_out <= lock_bits;
          endcase
        end
        `PPP_CMD_RSIG: data_out <= `PPP_ZERO8;
        default: data_out <= `PPP_ZERO8;
      endcase
    end
  end

  assign data_oe = prog_mode & ~read_drive_n;

  a_busy_level: assert property (@(posedge ref_clk) disable iff (!nrst)
    ready_busy_n == (st_reg == PPP_IDLE)) else $error("busy mismatch");
  a_bus_drive: assert property (@(posedge ref_clk) disable iff (!nrst)
    data_oe |-> !read_drive_n) else $error("bus driven without read");
  a_erase_start: assert property (@(posedge ref_clk) disable iff (!nrst)
    clk_en && prog_mode && wr_fall && !busy && cmd_reg == `PPP_CMD_ERASE
    |=> !ready_busy_n) else $error("erase not started");
  a_busy_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    busy |=> $stable(cmd_reg)) else $error("command changed while busy");
  a_cmd_load: assert property (@(posedge ref_clk) disable iff (!nrst)
    clk_en && prog_mode && ls_rise && !busy && act == `PPP_ACT_CMD
    |=> cmd_reg == $past(data_in)) else $error("command not loaded");
  a_addr_hi: assert property (@(posedge ref_clk) disable iff (!nrst)
    clk_en && prog_mode && ls_rise && !busy && act == `PPP_ACT_ADDR &&
    sel.byte_sel_first |=> addr_hi_reg == $past(data_in))
    else $error("high address not loaded");
  a_addr_keep: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_reg == PPP_PROG |=> $stable(addr)) else $error("address lost");
  a_prog_start: assert property (@(posedge ref_clk) disable iff (!nrst)
    clk_en && prog_mode && wr_fall && !busy && !sel.byte_sel_first &&
    cmd_reg == `PPP_CMD_WFLASH |=> st_reg == PPP_PROG)
    else $error("page program not started");
endmodule : ppp_port

// ### pkg/ppp_cfg.svh
`ifndef PPP_CFG_SVH
`define PPP_CFG_SVH
// strobe action codes
`define PPP_ACT_ADDR 2'h0
`define PPP_ACT_DATA 2'h1
`define PPP_ACT_CMD 2'h2
// command bytes
`define PPP_CMD_NOP 8'h00
`define PPP_CMD_ERASE 8'h80
`define PPP_CMD_WFUSE 8'h40
`define PPP_CMD_WLOCK 8'h20
`define PPP_CMD_WFLASH 8'h10
`define PPP_CMD_WEEP 8'h11
`define PPP_CMD_RSIG 8'h08
`define PPP_CMD_RFUSE 8'h04
`define PPP_CMD_RFLASH 8'h02
`define PPP_CMD_REEP 8'h03
// reset values
`define PPP_ZERO8 8'h00
`define PPP_ZERO16 16'h0000
`define PPP_ERASED8 8'hFF
`define PPP_ERASED16 16'hFFFF
// timing
`define PPP_ERASE_NS 10000
`define PPP_PROG_NS 5000
`define PPP_CLK_NS 5
`endif

// ### pkg/ppp_pkg.sv
package ppp_pkg;
  typedef struct packed {
    logic page_buffer_latch;
    logic strobe_action_msb;
    logic strobe_action_lsb;
    logic byte_sel_first;
    logic byte_sel_second;
  } ppp_sel_t;
  typedef enum logic [2:0] {
    PPP_IDLE = 3'b001,
    PPP_ERASE = 3'b010,
    PPP_PROG = 3'b100
  } ppp_state_t;
endpackage : ppp_pkg

// ### testbench/ppp_prog_model.sv
`timescale 1ns/10ps
module ppp_prog_model
  import ppp_pkg::*;
#(
  parameter int PW = 50
) (
  // clock
  input wire logic ref_clk,
  // programming pins
  output logic prog_mode,
  output logic load_strobe_pin,
  output ppp_pkg::ppp_sel_t sel,
  output logic read_drive_n,
  output logic program_strobe_n,
  output logic [7:0] data_in
);
  initial begin
    prog_mode = 1'b0;
    load_strobe_pin = 1'b0;
    sel = '0;
    read_drive_n = 1'b1;
    program_strobe_n = 1'b1;
    data_in = 8'h00;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : hold
  task automatic pulse_ld();
    load_strobe_pin = 1'b1;
    hold(PW);
    load_strobe_pin = 1'b0;
    hold(PW);
  endtask : pulse_ld
  // entry pattern, 20 cycles = 100 ns
  task automatic enter();
    repeat (6) pulse_ld();
    hold(20);
    prog_mode = 1'b1;
    hold(20);
  endtask : enter
  task automatic load(input logic [1:0] act, input logic bs1,
                      input logic [7:0] v);
    {sel.strobe_action_msb, sel.strobe_action_lsb} = act;
    sel.byte_sel_first = bs1;
    data_in = v;
    hold(1);
    pulse_ld();
  endtask : load
  task automatic latch();
    sel.byte_sel_first = 1'b1;
    sel.page_buffer_latch = 1'b1;
    hold(PW);
    sel.page_buffer_latch = 1'b0;
    hold(PW);
  endtask : latch
  task automatic wr_start(input logic bs1, input logic bs2);
    {sel.strobe_action_msb, sel.strobe_action_lsb} = 2'b11;
    sel.byte_sel_first = bs1;
    sel.byte_sel_second = bs2;
    hold(1);
    program_strobe_n = 1'b0;
  endtask : wr_start
  task automatic wr_end();
    hold(PW);
    program_strobe_n = 1'b1;
    hold(1);
  endtask : wr_end
  // byte select; released bus shows inverse
  task automatic rd_on(input logic bs1, input logic bs2);
    sel.byte_sel_first = bs1;
    sel.byte_sel_second = bs2;
    read_drive_n = 1'b0;
    data_in = ~data_in;
    hold(2);
  endtask : rd_on
  task automatic rd_off();
    read_drive_n = 1'b1;
    hold(1);
  endtask : rd_off
endmodule : ppp_prog_model

// ### testbench/tb_top.sv
`timescale 1ns/10ps
`include "ppp_cfg.svh"
module tb_top;
  import ppp_pkg::*;
  logic ref_clk, nrst, prog_mode, load_strobe_pin, read_drive_n;
  logic program_strobe_n, data_oe, ready_busy_n;
  ppp_sel_t sel;
  logic [7:0] data_in, data_out, fl, fh, fe, lock_bits, e;
  logic [15:0] w0, w1;
  logic [7:0] exp_q[$];
  int kind_q[$];
  int bad_count, n_compared, k, cyc;
  integer seed;
  event chk_ev;
  ppp_port #(.ERASE_CYC(6), .PROG_CYC(5)) DUT (.ref_clk(ref_clk),
    .nrst(nrst), .clk_en(1'b1), .prog_mode(prog_mode),
    .load_strobe_pin(load_strobe_pin), .sel(sel),
    .read_drive_n(read_drive_n), .program_strobe_n(program_strobe_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .ready_busy_n(ready_busy_n), .fuse_low_active(fl),
    .fuse_high_active(fh), .fuse_ext_active(fe), .lock_bits(lock_bits));
  ppp_prog_model prog (.ref_clk(ref_clk), .prog_mode(prog_mode),
    .load_strobe_pin(load_strobe_pin), .sel(sel),
    .read_drive_n(read_drive_n), .program_strobe_n(program_strobe_n),
    .data_in(data_in));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic cmp_byte(input string nm, input logic [7:0] x,
                          input logic [7:0] g);
    n_compared++;
    if (g !== x) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask : cmp_byte
  task automatic cmp_bit(input string nm, input logic x, input logic g);
    n_compared++;
    if (g !== x) begin
      bad_count++;
      $display("wrong value %s expected %b seen %b", nm, x, g);
    end
  endtask : cmp_bit
  task automatic note(input int kd, input logic [7:0] v);
    kind_q.push_back(kd);
    exp_q.push_back(v);
    ->chk_ev;
    // let the watcher compare before any pin moves again
    wait (exp_q.size() == 0);
  endtask : note
  always @(chk_ev) begin
    while (exp_q.size() > 0) begin
      k = kind_q.pop_front();
      e = exp_q.pop_front();
      case (k)
        0: cmp_byte("data_out", e, data_out);
        1: cmp_byte("lock_bits", e, lock_bits);
        2: cmp_byte("fuse_high_active", e, fh);
        3: cmp_bit("ready_busy_n", e[0], ready_busy_n);
        5: cmp_byte("fuse_low_active", e, fl);
        6: cmp_byte("fuse_ext_active", e, fe);
        default: cmp_bit("data_oe", e[0], data_oe);
      endcase
    end
  end
  task automatic rd(input logic bs1, input logic [7:0] x);
    prog.rd_on(bs1, 1'b0);
    note(0, x);
    note(4, 8'h01);
    prog.rd_off();
    note(4, 8'h00);
  endtask : rd
  task automatic rd_mem(input logic [7:0] c, input logic [15:0] a,
                        input logic [7:0] x);
    prog.load(2'b10, 1'b0, c);
    prog.load(2'b00, 1'b1, a[15:8]);
    prog.load(2'b00, 1'b0, a[7:0]);
    rd(1'b0, x);
  endtask : rd_mem
  task automatic put_word(input logic [7:0] lo, input logic [15:0] w);
    prog.load(2'b00, 1'b0, lo);
    prog.load(2'b01, 1'b0, w[7:0]);
    prog.load(2'b01, 1'b1, w[15:8]);
    prog.latch();
  endtask : put_word
  task automatic run_wr(input logic bs1);
    int n;
    n = 0;
    prog.wr_start(bs1, 1'b0);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    note(3, 8'h00);
    prog.wr_end();
    while (ready_busy_n !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    note(3, 8'h01);
  endtask : run_wr
  initial begin
    cyc = 0;
    forever begin
      @(posedge ref_clk);
      cyc++;
      if (cyc == 30000) begin
        bad_count++;
        end_of_test();
      end
    end
  end
  initial begin
    seed = 32'he97d_8274;
    nrst = 1'b0;
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    nrst = 1'b1;
    note(3, 8'h01);
    note(1, 8'hFF);
    note(5, 8'hFF);
    note(6, 8'hFF);
    prog.enter();
    w0 = 16'($random(seed));
    w1 = 16'($random(seed));
    prog.load(2'b10, 1'b0, `PPP_CMD_WFLASH);
    put_word(8'h85, w0);
    put_word(8'h86, w1);
    prog.load(2'b00, 1'b1, 8'h01);
    run_wr(1'b0);
    rd_mem(`PPP_CMD_RFLASH, 16'h0185, w0[7:0]);
    rd(1'b1, w0[15:8]);
    prog.load(2'b00, 1'b0, 8'h86);
    rd(1'b0, w1[7:0]);
    rd(1'b1, w1[15:8]);
    prog.load(2'b00, 1'b0, 8'h87);
    rd(1'b0, 8'hFF);
    prog.load(2'b10, 1'b0, `PPP_CMD_WFLASH);
    put_word(8'h10, w1);
    prog.load(2'b10, 1'b0, `PPP_CMD_NOP);
    prog.load(2'b10, 1'b0, `PPP_CMD_WFLASH);
    prog.load(2'b00, 1'b1, 8'h02);
    run_wr(1'b0);
    rd_mem(`PPP_CMD_RFLASH, 16'h0210, 8'hFF);
    prog.load(2'b10, 1'b0, `PPP_CMD_WEEP);
    prog.load(2'b00, 1'b1, 8'h00);
    prog.load(2'b00, 1'b0, 8'h03);
    prog.load(2'b01, 1'b0, w1[7:0]);
    prog.latch();
    run_wr(1'b0);
    rd_mem(`PPP_CMD_REEP, 16'h0003, w1[7:0]);
    prog.load(2'b10, 1'b0, `PPP_CMD_WLOCK);
    prog.load(2'b01, 1'b0, 8'hFC);
    run_wr(1'b0);
    note(1, 8'hFC);
    prog.load(2'b10, 1'b0, `PPP_CMD_WFUSE);
    prog.load(2'b01, 1'b0, 8'hF7);
    run_wr(1'b1);
    note(2, 8'hFF);
    prog.load(2'b10, 1'b0, `PPP_CMD_WFUSE);
    prog.load(2'b01, 1'b0, 8'hF0);
    run_wr(1'b0);
    prog.load(2'b10, 1'b0, `PPP_CMD_RFUSE);
    rd(1'b0, 8'hF0);
    rd(1'b1, 8'hFC);
    prog.load(2'b10, 1'b0, `PPP_CMD_ERASE);
    run_wr(1'b0);
    note(1, 8'hFF);
    rd_mem(`PPP_CMD_RFLASH, 16'h0185, 8'hFF);
    rd_mem(`PPP_CMD_REEP, 16'h0003, w1[7:0]);
    prog.load(2'b10, 1'b0, `PPP_CMD_WFUSE);
    prog.load(2'b01, 1'b0, 8'hFF);
    run_wr(1'b1);
    prog.load(2'b10, 1'b0, `PPP_CMD_ERASE);
    run_wr(1'b0);
    rd_mem(`PPP_CMD_REEP, 16'h0003, 8'hFF);
    @(negedge ref_clk);
    end_of_test();
  end
endmodule : tb_top
